// ### hdl/sca_channel_access.sv
// sca_channel_access: slotted channel access with acknowledgment priority
// assumes a frame queue on the same clock, a carrier pin, AXI4-Lite master
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sca_channel_access #(
	parameter int TICK_CYCLES = sca_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// channel
	input wire logic carrierDetect,
	// receiver
	input wire logic rxFrameValid,
	input wire logic [55:0] rxDestAddr,
	// transmit queue
	input wire logic txReq,
	input wire logic txIsAck,
	output logic txGrant,
	input wire logic ackHeard,
	output logic retryExpire
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	sca_pkg::sca_state_t state_r;
	logic cdMeta_r, cdSync_r;
	logic tick;
	logic [15:0] randVal;
	logic [1:0] ctrl_r;
	logic [6:0] slots_r, drawReg_r;
	logic [7:0] latency_r, respDur_r, slotLeft_r, perSlot_r, slotLen;
	logic [15:0] retryTime_r, retryLeft_r;
	logic [31:0] ownLo_r;
	logic [23:0] ownHi_r;
	logic [8:0] guardLeft_r;
	logic deferPending_r, retryRun_r, txGrant_r, retryExpire_r;
	logic prioEn, slotEn, ackNow, rxForOther, grantNxt;
	logic [6:0] drawNxt;
	logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r, rdata_r;
	logic [3:0] wStrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] wrOld, wrWord;

	// register index from byte address; 4'hf marks an unmapped word
	function automatic logic [3:0] regSel(input logic [7:0] addr);
		if (addr == sca_pkg::CTRL_OFFSET) return 4'h0;
		else if (addr == sca_pkg::SLOTS_OFFSET) return 4'h1;
		else if (addr == sca_pkg::LATENCY_OFFSET) return 4'h2;
		else if (addr == sca_pkg::RESPDUR_OFFSET) return 4'h3;
		else if (addr == sca_pkg::RETRY_OFFSET) return 4'h4;
		else if (addr == sca_pkg::OWNLO_OFFSET) return 4'h5;
		else if (addr == sca_pkg::OWNHI_OFFSET) return 4'h6;
		else if (addr == sca_pkg::STATUS_OFFSET) return 4'h7;
		else return 4'hf;
	endfunction : regSel

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
		return res;
	endfunction : mergeStrb

	// clamp a setting to its top value
	function automatic logic [7:0] clampSet(input logic [7:0] v);
		return (v > sca_pkg::SETTING_MAX) ? sca_pkg::SETTING_MAX : v;
	endfunction : clampSet

	////////////////////////////////////////////////////////////////////////////
	// time base and random source

	sca_tick_rand #(
		.TICK_CYCLES(TICK_CYCLES)
	) uTickRand (
		.clk(clk),
		.rstn(rstn),
		.tick(tick),
		.randVal(randVal)
	);

	// carrier pin comes from the radio, two flops before use
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cdMeta_r <= 1'b0;
			cdSync_r <= 1'b0;
		end
		else
		begin
			cdMeta_r <= carrierDetect;
			cdSync_r <= cdMeta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// arbiter

	assign prioEn = ctrl_r[sca_pkg::CTRL_PRIO_BIT];
	assign slotEn = ctrl_r[sca_pkg::CTRL_SLOT_BIT];
	assign ackNow = txIsAck && prioEn && !cdSync_r;
	assign rxForOther = rxFrameValid && (rxDestAddr != {ownHi_r, ownLo_r});
	// modulo gives n+1 outcomes; bias from 16 random bits is negligible
	assign drawNxt = 7'(randVal % {8'h0, 8'({1'b0, slots_r}) + 8'h1});
	// a zero latency still gets one tick so a slot is never empty
	assign slotLen = (latency_r == 8'h0) ? 8'h1 : latency_r;

	// grant decision for the current cycle
	always_comb
	begin
		grantNxt = 1'b0;
		case (state_r)
			sca_pkg::ST_WAIT: grantNxt = txReq && (ackNow || (!slotEn && !cdSync_r));
			sca_pkg::ST_GUARD: grantNxt = txReq && ackNow;
			sca_pkg::ST_SLOT: grantNxt = txReq && !cdSync_r && (ackNow || slotLeft_r == 8'h0);
			default: grantNxt = 1'b0;
		endcase
	end

	// access state machine; the guard loads one extra tick so it is never short
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= sca_pkg::ST_IDLE;
			guardLeft_r <= 9'h0;
			slotLeft_r <= 8'h0;
			perSlot_r <= 8'h0;
			drawReg_r <= 7'h0;
		end
		else
		begin
			case (state_r)
				sca_pkg::ST_IDLE:
					if (txReq) state_r <= sca_pkg::ST_WAIT;
				sca_pkg::ST_WAIT:
					if (!txReq) state_r <= sca_pkg::ST_IDLE;
					else if (grantNxt) state_r <= sca_pkg::ST_SEND;
					else if (slotEn && !cdSync_r)
					begin
						state_r <= sca_pkg::ST_GUARD;
						drawReg_r <= drawNxt;
						guardLeft_r <= 9'(latency_r) + 9'(respDur_r) + 9'h1;
					end
				sca_pkg::ST_GUARD:
					if (!txReq) state_r <= sca_pkg::ST_IDLE;
					else if (grantNxt) state_r <= sca_pkg::ST_SEND;
					else if (cdSync_r) state_r <= sca_pkg::ST_WAIT;
					else if (tick)
					begin
						if (guardLeft_r == 9'h1)
						begin
							state_r <= sca_pkg::ST_SLOT;
							slotLeft_r <= (drawReg_r == 7'h0 && deferPending_r) ? 8'h1
								: {1'b0, drawReg_r};
							perSlot_r <= slotLen;
						end
						else
							guardLeft_r <= guardLeft_r - 9'h1;
					end
				sca_pkg::ST_SLOT:
					if (!txReq) state_r <= sca_pkg::ST_IDLE;
					else if (grantNxt) state_r <= sca_pkg::ST_SEND;
					else if (cdSync_r) state_r <= sca_pkg::ST_WAIT;
					else if (tick)
					begin
						if (perSlot_r == 8'h1)
						begin
							slotLeft_r <= slotLeft_r - 8'h1;
							perSlot_r <= slotLen;
						end
						else
							perSlot_r <= perSlot_r - 8'h1;
					end
				sca_pkg::ST_SEND:
					if (!txReq) state_r <= sca_pkg::ST_IDLE;
				default: state_r <= sca_pkg::ST_IDLE;
			endcase
		end
	end

	// one-cycle key pulse as the arbiter enters send
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			txGrant_r <= 1'b0;
		else
			txGrant_r <= grantNxt;
	end

	// deferral after a frame heard for another station; setting wins over consuming
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			deferPending_r <= 1'b0;
		else if (rxForOther)
			deferPending_r <= 1'b1;
		else if (grantNxt && !ackNow)
			deferPending_r <= 1'b0;
	end

	// retry timer starts at the frame's start, as the far side expects
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			retryRun_r <= 1'b0;
			retryLeft_r <= 16'h0;
			retryExpire_r <= 1'b0;
		end
		else
		begin
			retryExpire_r <= 1'b0;
			if (grantNxt && !ackNow)
			begin
				retryRun_r <= 1'b1;
				retryLeft_r <= retryTime_r;
			end
			else if (ackHeard)
				retryRun_r <= 1'b0;
			else if (retryRun_r && tick)
			begin
				if (retryLeft_r <= 16'h1)
				begin
					retryRun_r <= 1'b0;
					retryExpire_r <= 1'b1;
				end
				else
					retryLeft_r <= retryLeft_r - 16'h1;
			end
		end
	end

	assign txGrant = txGrant_r;
	assign retryExpire = retryExpire_r;

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave

	assign awready = !awHeld_r && !bvalid_r;
	assign wready = !wHeld_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

	// write path: address and data taken in either order, response after both
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= sca_pkg::RESP_OKAY;
			awAddr_r <= 8'h0;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= {awaddr[7:2], 2'h0};
			end
			if (wvalid && wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			if (awHeld_r && wHeld_r)
			begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (regSel(awAddr_r) == 4'hf) ? sca_pkg::RESP_SLVERR : sca_pkg::RESP_OKAY;
			end
			else if (bvalid_r && bready)
				bvalid_r <= 1'b0;
		end
	end

	// old contents of the addressed word, so partial strobes keep untouched lanes
	always_comb
	begin
		wrOld = 32'h0;
		case (regSel(awAddr_r))
			4'h0: wrOld = {30'h0, ctrl_r};
			4'h1: wrOld = {25'h0, slots_r};
			4'h2: wrOld = {24'h0, latency_r};
			4'h3: wrOld = {24'h0, respDur_r};
			4'h4: wrOld = {16'h0, retryTime_r};
			4'h5: wrOld = ownLo_r;
			4'h6: wrOld = {8'h0, ownHi_r};
			default: wrOld = 32'h0;
		endcase
	end

	assign wrWord = mergeStrb(wrOld, wData_r, wStrb_r);

	// register file; status is read-only so its writes are dropped
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_r <= sca_pkg::CTRL_RESET;
			slots_r <= sca_pkg::SLOTS_RESET;
			latency_r <= sca_pkg::LATENCY_RESET;
			respDur_r <= sca_pkg::RESPDUR_RESET;
			retryTime_r <= sca_pkg::RETRY_RESET;
			ownLo_r <= 32'h0;
			ownHi_r <= 24'h0;
		end
		else if (awHeld_r && wHeld_r)
		begin
			case (regSel(awAddr_r))
				4'h0: ctrl_r <= wrWord[1:0];
				4'h1: slots_r <= wrWord[6:0];
				4'h2: latency_r <= clampSet(wrWord[7:0]);
				4'h3: respDur_r <= clampSet(wrWord[7:0]);
				4'h4: retryTime_r <= wrWord[15:0];
				4'h5: ownLo_r <= wrWord;
				4'h6: ownHi_r <= wrWord[23:0];
				default: ;
			endcase
		end
	end

	// read path: one cycle from address to data
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= sca_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= sca_pkg::RESP_OKAY;
			case (regSel({araddr[7:2], 2'h0}))
				4'h0: rdata_r <= {30'h0, ctrl_r};
				4'h1: rdata_r <= {25'h0, slots_r};
				4'h2: rdata_r <= {24'h0, latency_r};
				4'h3: rdata_r <= {24'h0, respDur_r};
				4'h4: rdata_r <= {16'h0, retryTime_r};
				4'h5: rdata_r <= ownLo_r;
				4'h6: rdata_r <= {8'h0, ownHi_r};
				4'h7: rdata_r <= {retryLeft_r, 1'b0, drawReg_r, 2'h0, 3'(state_r), retryRun_r,
					deferPending_r, cdSync_r};
				default:
				begin
					rdata_r <= 32'h0;
					rresp_r <= sca_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_r && rready)
			rvalid_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	guard_start_idle_a: assert property (
		(state_r == sca_pkg::ST_GUARD && $past(state_r) == sca_pkg::ST_WAIT) |-> $past(!cdSync_r))
		else $error("countdown started while carrier busy");
	ack_no_delay_a: assert property (
		(state_r inside {sca_pkg::ST_WAIT, sca_pkg::ST_GUARD} && txReq && txIsAck && prioEn
		&& !cdSync_r) |=> txGrant)
		else $error("acknowledgment delayed");
	grant_carrier_clear_a: assert property (
		txGrant |-> $past(!cdSync_r))
		else $error("grant given while carrier busy");
	defer_on_other_a: assert property (
		(rxFrameValid && rxDestAddr != {ownHi_r, ownLo_r}) |=> deferPending_r)
		else $error("frame for another station did not defer");
	slot_after_guard_a: assert property (
		(state_r == sca_pkg::ST_SLOT && $past(state_r) != sca_pkg::ST_SLOT)
		|-> ($past(state_r) == sca_pkg::ST_GUARD && $past(guardLeft_r) == 9'h1 && $past(tick)))
		else $error("slot countdown without full guard");
	defer_one_slot_a: assert property (
		(state_r == sca_pkg::ST_SLOT && $past(state_r) == sca_pkg::ST_GUARD
		&& $past(deferPending_r)) |-> slotLeft_r >= 8'h1)
		else $error("deferral shorter than one slot");
	guard_load_a: assert property (
		(state_r == sca_pkg::ST_GUARD && $past(state_r) == sca_pkg::ST_WAIT)
		|-> guardLeft_r == 9'($past(latency_r)) + 9'($past(respDur_r)) + 9'h1)
		else $error("guard time not latency plus duration");
	setting_range_a: assert property (
		latency_r <= sca_pkg::SETTING_MAX && respDur_r <= sca_pkg::SETTING_MAX)
		else $error("setting above its limit");
	draw_range_a: assert property (
		(state_r == sca_pkg::ST_GUARD && $past(state_r) == sca_pkg::ST_WAIT)
		|-> drawReg_r <= $past(slots_r))
		else $error("slot draw out of range");
	carrier_abort_a: assert property (
		(state_r inside {sca_pkg::ST_GUARD, sca_pkg::ST_SLOT} && cdSync_r && txReq
		&& !ackNow) |=> state_r == sca_pkg::ST_WAIT)
		else $error("countdown not aborted by carrier");
	retry_load_a: assert property (
		(grantNxt && !ackNow) |=> (retryRun_r && retryLeft_r == $past(retryTime_r)))
		else $error("retry timer not started with frame");
	plain_access_a: assert property (
		(state_r == sca_pkg::ST_WAIT && txReq && !slotEn && !cdSync_r) |=> txGrant)
		else $error("plain access delayed");

endmodule : sca_channel_access
`default_nettype wire

// ### hdl/sca_tick_rand.sv
// sca_tick_rand: 10 ms tick divider and free-running pseudo-random source
// assumes one clock; the tick is a one-cycle enable for the arbiter's counters
`timescale 1ns/1ps
`default_nettype none
module sca_tick_rand #(
	parameter int TICK_CYCLES = sca_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// outputs
	output logic tick,
	output logic [15:0] randVal
);

	logic [31:0] divCnt_r;
	logic [15:0] lfsr_r;

	// divider: tick fires on the last cycle of each period
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			divCnt_r <= 32'h0;
		else if (divCnt_r == 32'(TICK_CYCLES - 1))
			divCnt_r <= 32'h0;
		else
			divCnt_r <= divCnt_r + 32'h1;
	end

	assign tick = (divCnt_r == 32'(TICK_CYCLES - 1));

	// maximal-length lfsr, steps every clock so draws decorrelate between stations
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lfsr_r <= 16'hace1;
		else
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
	end

	assign randVal = lfsr_r;

	tick_period_a: assert property (@(posedge clk) disable iff (!rstn)
		tick |=> !tick)
		else $error("tick lasted more than one cycle");

endmodule : sca_tick_rand
`default_nettype wire

// ### shared/sca_pkg.sv
// sca_pkg: constants for the slotted channel access arbiter
// assumes a 125 MHz controller clock and a 32-bit AXI4-Lite register bus
`default_nettype none
package sca_pkg;

	// clock and time base
	localparam int CLK_FREQ_HZ = 125_000_000;
	localparam int TICK_PERIOD_MS = 10;
	localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] SLOTS_OFFSET = 8'h04;
	localparam logic [7:0] LATENCY_OFFSET = 8'h08;
	localparam logic [7:0] RESPDUR_OFFSET = 8'h0c;
	localparam logic [7:0] RETRY_OFFSET = 8'h10;
	localparam logic [7:0] OWNLO_OFFSET = 8'h14;
	localparam logic [7:0] OWNHI_OFFSET = 8'h18;
	localparam logic [7:0] STATUS_OFFSET = 8'h1c;

	// control field positions
	localparam int CTRL_PRIO_BIT = 0;
	localparam int CTRL_SLOT_BIT = 1;

	// setting limits
	localparam logic [7:0] SETTING_MAX = 8'hfa;
	localparam logic [6:0] SLOTS_MAX = 7'h7f;

	// reset values
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [6:0] SLOTS_RESET = 7'h04;
	localparam logic [7:0] LATENCY_RESET = 8'h03;
	localparam logic [7:0] RESPDUR_RESET = 8'h0a;
	localparam logic [15:0] RETRY_RESET = 16'h012c;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// arbiter states
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_GUARD, ST_SLOT, ST_SEND} sca_state_t;

endpackage : sca_pkg
`default_nettype wire

// ### verification/sca_station_model.sv
// sca_station_model: the other stations sharing the simplex radio channel
// assumes the bench calls its task right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module sca_station_model (
	// clock
	input wire logic clk,
	// channel as the arbiter sees it
	output logic carrierDetect,
	output logic rxFrameValid,
	output logic [55:0] rxDestAddr
);
	////////////////////////////////////////
	// quiet channel, nothing decoded yet
	initial
	begin
		carrierDetect = 1'b0;
		rxFrameValid = 1'b0;
		rxDestAddr = 56'h0;
	end
	////////////////////////////////////////
	// one frame on air: carrier for len cycles, then its decoded address
	// address is inverted after the pulse so a stale value never matches
	task automatic sendFrame(input int len, input logic [55:0] dest);
		carrierDetect <= 1'b1;
		repeat (len) @(posedge clk);
		carrierDetect <= 1'b0;
		rxFrameValid <= 1'b1;
		rxDestAddr <= dest;
		@(posedge clk);
		rxFrameValid <= 1'b0;
		rxDestAddr <= ~dest;
	endtask : sendFrame
endmodule : sca_station_model
`default_nettype wire

// ### verification/tb_slotted_channel_access.sv
// tb_slotted_channel_access: self-checking bench for the channel arbiter
// assumes a 20-cycle tick, so one 10 ms unit lasts 20 clocks here
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nErrors++; \
	$display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb_slotted_channel_access;
	localparam int T = 20;
	logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, txGrant, retryExpire;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd32;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic carrierDetect, rxFrameValid, txReq, txIsAck, ackHeard, dfr;
	logic [55:0] rxDestAddr, own;
	logic [31:0] rstTab [7];
	int nErrors = 0, cmpCount = 0, cyc = 0, t, i, m, lv, rv, sv;
	////////////////////////////////////////
	sca_channel_access #(.TICK_CYCLES(T)) DUT (.clk(clk), .rstn(rstn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .carrierDetect(carrierDetect),
		.rxFrameValid(rxFrameValid), .rxDestAddr(rxDestAddr), .txReq(txReq),
		.txIsAck(txIsAck), .txGrant(txGrant), .ackHeard(ackHeard),
		.retryExpire(retryExpire));
	sca_station_model STN (.clk(clk), .carrierDetect(carrierDetect),
		.rxFrameValid(rxFrameValid), .rxDestAddr(rxDestAddr));
	// clock, and a cycle ceiling well past the longest expected run
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			nErrors++;
			printVerdict();
		end
	end
	////////////////////////////////////////
	task automatic printVerdict();
		$display("checks=%0d errors=%0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : printVerdict
	// bus write: both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		if (bvalid !== 1'b1) nErrors++; // write answer never came
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		if (rvalid !== 1'b1) nErrors++; // read answer never came
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	////////////////////////////////////////
	task automatic waitGrant(input int lim, output int n);
		n = 0;
		while (txGrant !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask : waitGrant
	// queue a frame while another station holds the channel
	task automatic runFrame(input int len, input logic [55:0] dest, input logic ack);
		fork
			STN.sendFrame(len, dest);
			begin
				repeat (3) @(posedge clk);
				txReq <= 1'b1;
				txIsAck <= ack;
				waitGrant(len - 6, t);
				`CHK("held while busy", 1'b0, txGrant)
			end
		join
	endtask : runFrame
	task automatic finishGrant();
		@(posedge clk);
		`CHK("grant pulse", 1'b0, txGrant)
		txReq <= 1'b0;
		txIsAck <= 1'b0;
		@(posedge clk);
	endtask : finishGrant
	// guard plus forced slot, and the latest grant allowed for the draw
	function automatic int loBound(int l, int r, logic d);
		return (l + r + (d ? l : 0)) * T;
	endfunction : loBound
	function automatic int hiBound(int l, int r, int s, logic d);
		return (l + r + 1 + ((s == 0 && d) ? 1 : s) * l) * T + 6;
	endfunction : hiBound
	////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h4e10));
		{rstn, awvalid, wvalid, bready, arvalid, rready, txReq, txIsAck, ackHeard} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rstTab = '{32'(sca_pkg::CTRL_RESET), 32'(sca_pkg::SLOTS_RESET),
			32'(sca_pkg::LATENCY_RESET), 32'(sca_pkg::RESPDUR_RESET),
			32'(sca_pkg::RETRY_RESET), 32'h0, 32'h0};
		for (i = 0; i < 7; i++)
		begin
			rd(8'(i * 4), rd32, rsp);
			`CHK("reset value", rstTab[i], rd32)
		end
		rd(8'h20, rd32, rsp);
		`CHK("unmapped read", sca_pkg::RESP_SLVERR, rsp)
		wr(8'h24, 32'h1, rsp);
		`CHK("unmapped write", sca_pkg::RESP_SLVERR, rsp)
		wr(sca_pkg::LATENCY_OFFSET, 32'hff, rsp);
		rd(sca_pkg::LATENCY_OFFSET, rd32, rsp);
		`CHK("latency clamp", {24'h0, sca_pkg::SETTING_MAX}, rd32)
		own[31:0] = $urandom;
		own[55:32] = 24'($urandom);
		wr(sca_pkg::OWNLO_OFFSET, own[31:0], rsp);
		wr(sca_pkg::OWNHI_OFFSET, {8'h0, own[55:32]}, rsp);
		wr(sca_pkg::RETRY_OFFSET, 32'h3, rsp);
		// destination decode: own address leaves no deferral, another sets it
		STN.sendFrame(4, own);
		rd(sca_pkg::STATUS_OFFSET, rd32, rsp);
		`CHK("defer own", 1'b0, rd32[1])
		STN.sendFrame(4, ~own);
		rd(sca_pkg::STATUS_OFFSET, rd32, rsp);
		`CHK("defer other", 1'b1, rd32[1])
		// priority ack, then plain access with and without an answer heard
		for (m = 0; m < 3; m++)
		begin
			wr(sca_pkg::CTRL_OFFSET, (m == 0) ? 32'h3 : 32'h0, rsp);
			runFrame(40, ~own, m == 0);
			waitGrant(8, t);
			`CHK("prompt grant", 1'b1, txGrant)
			finishGrant();
			if (m > 0)
			begin
				ackHeard <= (m == 2);
				@(posedge clk);
				ackHeard <= 1'b0;
				waitRetry();
				`CHK("retry expiry", m == 1, t >= 2 * T - 4 && t < 4 * T)
			end
		end
		// slotted access with random settings; first two without a draw
		wr(sca_pkg::CTRL_OFFSET, 32'h2, rsp);
		for (i = 0; i < 8; i++)
		begin
			lv = $urandom_range(3, 2);
			rv = $urandom_range(3, 0);
			sv = (i < 2) ? 0 : $urandom_range(3, 0);
			dfr = i[0];
			wr(sca_pkg::LATENCY_OFFSET, 32'(lv), rsp);
			wr(sca_pkg::RESPDUR_OFFSET, 32'(rv), rsp);
			wr(sca_pkg::SLOTS_OFFSET, 32'(sv), rsp);
			runFrame(30, dfr ? ~own : own, 1'b0);
			waitGrant(hiBound(lv, rv, sv, dfr) + 1, t);
			`CHK("slot wait low", 1'b1, t >= loBound(lv, rv, dfr))
			`CHK("slot wait high", 1'b1, t <= hiBound(lv, rv, sv, dfr))
			finishGrant();
		end
		// carrier back in mid-guard: countdown restarts in full
		wr(sca_pkg::SLOTS_OFFSET, 32'h0, rsp);
		runFrame(30, own, 1'b0);
		waitGrant(2 * T, t);
		`CHK("guard abort", 1'b0, txGrant)
		runFrame(20, own, 1'b0);
		waitGrant(hiBound(lv, rv, 0, 0) + 1, t);
		`CHK("restart low", 1'b1, t >= loBound(lv, rv, 0))
		`CHK("restart high", 1'b1, t <= hiBound(lv, rv, 0, 0))
		finishGrant();
		printVerdict();
	end
	// bounded wait for the retry timer, leaves the count in t
	task automatic waitRetry();
		t = 0;
		while (retryExpire !== 1'b1 && t < 4 * T)
		begin
			@(posedge clk);
			t++;
		end
	endtask : waitRetry
endmodule : tb_slotted_channel_access
`default_nettype wire
